/* verilog/ulpi_evt_map.svh */
`ifndef ULPI_EVT_MAP_SVH
`define ULPI_EVT_MAP_SVH
`define ADDR_RISE_EN_WR 8'h0d
`define ADDR_RISE_EN_SET 8'h0e
`define ADDR_RISE_EN_CLR 8'h0f
`define ADDR_FALL_EN_WR 8'h10
`define ADDR_FALL_EN_SET 8'h11
`define ADDR_FALL_EN_CLR 8'h12
`define ADDR_LEVEL 8'h13
`define ADDR_LATCH 8'h14
`define ADDR_DEBUG 8'h15
`define ADDR_SCRATCH_WR 8'h16
`define ADDR_SCRATCH_SET 8'h17
`define ADDR_SCRATCH_CLR 8'h18
`define ADDR_UNIMP_LO 8'h19
`define ADDR_UNIMP_HI 8'h2e
`define ADDR_EXT_ESCAPE 8'h2f
`define ADDR_IMM_LAST 8'h3f
`define EVT_WIDTH 5
`define EN_RESET 5'h1f
`define LATCH_RESET 5'h00
`define SCRATCH_RESET 8'h00
`define BYTE_ZERO 8'h00
`endif

/* verilog/ulpi_evt_pkg.sv */
package ulpi_evt_pkg;
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_SET,
    OP_CLEAR
  } reg_op_t;
  typedef struct packed {
    logic id_grounded;
    logic session_ended;
    logic session_ok;
    logic bus_power_ok;
    logic host_unplug_detect;
  } evt_src_t;
  typedef struct packed {
    logic line_condition_hi;
    logic line_condition_lo;
  } line_cond_t;
endpackage : ulpi_evt_pkg

/* verilog/sync_two_ff.sv */
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : sync_two_ff

/* verilog/rw_set_clr_reg.sv */
`timescale 1ns/1ps
module rw_set_clr_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Access
  input wire logic wr_i,
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] value_o
);
  wire [WIDTH-1:0] next_value = wr_i ? data_i :
                                set_i ? (value_o | data_i) :
                                clr_i ? (value_o & ~data_i) : value_o;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= RESET_VALUE;
    end else begin
      value_o <= next_value;
    end
  end
endmodule : rw_set_clr_reg

/* verilog/ulpi_phy_event_status_regs.sv */
// Summary of operation
// RL1 - A one-to-zero source change with falling enable raises interrupt and RXCMD.
// RL2 - Falling enables reset to ones in bits 4..0; bits 7..5 reset zero.
// RL3 - Falling enables: write 10h, set 11h, clear 12h, read 10h-12h.
// RL4 - Falling enable bits 4..0 gate ID, session end, session ok, power, unplug.
// RL5 - Level register at 13h returns present unlatched source values.
// RL6 - Level bits 4..0 follow ID, session end, session ok, power, unplug.
// RL7 - Latch register at 14h sets a bit on each unmasked source change.
// RL8 - All latch bits clear on a latch read or on low-power entry; the code keeps bits set by an event in that same cycle.
// RL9 - Link may skip latch reads; RXCMDs carry the same information.
// RL10 - Debug register at 15h shows two line condition bits, rest zero.
// RL11 - Scratch byte resets 00h; write 16h, set 17h, clear 18h, no effect.
// RL12 - Addresses 19h to 2Eh unimplemented; accesses change nothing.
// RL13 - Address 2Fh holds no data and escapes to extended set.
// RL14 - Rising enables at 0Dh/0Eh/0Fh gate zero-to-one changes, reset all on.
// RL15 - Extended 00h-3Fh map to immediate registers; 40h-FFh unimplemented.
// RL16 - Set address ORs written byte; clear address clears bits written one.
// RL17 - Only enabled rising or falling changes set latches or send RXCMDs.
`timescale 1ns/1ps
`include "ulpi_evt_map.svh"
module ulpi_phy_event_status_regs #(
  parameter int EVT_W = `EVT_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register access from the ULPI command decoder
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic ext_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic ext_escape_o,
  // Analog sources and line state
  input wire ulpi_evt_pkg::evt_src_t evt_src_i,
  input wire ulpi_evt_pkg::line_cond_t line_cond_i,
  input wire logic low_power_enter_i,
  // Event reporting
  output logic event_irq_o,
  output logic rxcmd_req_o,
  output ulpi_evt_pkg::evt_src_t rxcmd_level_o
);
  // Comparators are asynchronous to the PHY clock
  logic [EVT_W-1:0] src_sync;
  logic [1:0] line_sync;
  logic [EVT_W-1:0] src_prev;
  logic [EVT_W-1:0] latch;
  logic [EVT_W-1:0] rise_en;
  logic [EVT_W-1:0] fall_en;
  logic [7:0] scratch;

  sync_two_ff #(.WIDTH(EVT_W)) u_src_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(evt_src_i),
    .sync_o(src_sync)
  );
  sync_two_ff #(.WIDTH(2)) u_line_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(line_cond_i),
    .sync_o(line_sync)
  );

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  // Extended space above 3Fh ignores writes and reads zero [RL15]
  wire addr_ok = !ext_i || (reg_addr_i <= `ADDR_IMM_LAST);
  wire wr = reg_wr_i && addr_ok;
  wire rd = reg_rd_i && addr_ok;
  // 2Fh only flags the escape; stores nothing [RL13]
  assign ext_escape_o = reg_wr_i && !ext_i && addr_is(reg_addr_i, `ADDR_EXT_ESCAPE);

  // Set ORs, clear masks with written ones [RL16]
  wire rw_wr = wr && addr_is(reg_addr_i, `ADDR_RISE_EN_WR);
  wire rs_wr = wr && addr_is(reg_addr_i, `ADDR_RISE_EN_SET);
  wire rc_wr = wr && addr_is(reg_addr_i, `ADDR_RISE_EN_CLR);
  wire fw_wr = wr && addr_is(reg_addr_i, `ADDR_FALL_EN_WR); // [RL3]
  wire fs_wr = wr && addr_is(reg_addr_i, `ADDR_FALL_EN_SET); // [RL3]
  wire fc_wr = wr && addr_is(reg_addr_i, `ADDR_FALL_EN_CLR); // [RL3]
  wire sw_wr = wr && addr_is(reg_addr_i, `ADDR_SCRATCH_WR); // [RL11]
  wire ss_wr = wr && addr_is(reg_addr_i, `ADDR_SCRATCH_SET); // [RL11]
  wire sc_wr = wr && addr_is(reg_addr_i, `ADDR_SCRATCH_CLR); // [RL11]

  // Upper bits of enables are stored too, so reserved bits read back
  logic [7:0] rise_reg;
  logic [7:0] fall_reg;
  rw_set_clr_reg #(.WIDTH(8), .RESET_VALUE({3'h0, `EN_RESET})) u_rise_en (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(rw_wr),
    .set_i(rs_wr),
    .clr_i(rc_wr),
    .data_i(reg_wdata_i),
    .value_o(rise_reg)
  ); // [RL14]
  rw_set_clr_reg #(.WIDTH(8), .RESET_VALUE({3'h0, `EN_RESET})) u_fall_en (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(fw_wr),
    .set_i(fs_wr),
    .clr_i(fc_wr),
    .data_i(reg_wdata_i),
    .value_o(fall_reg)
  ); // [RL2]
  rw_set_clr_reg #(.WIDTH(8), .RESET_VALUE(`SCRATCH_RESET)) u_scratch (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(sw_wr),
    .set_i(ss_wr),
    .clr_i(sc_wr),
    .data_i(reg_wdata_i),
    .value_o(scratch)
  ); // [RL11]
  assign rise_en = rise_reg[EVT_W-1:0];
  assign fall_en = fall_reg[EVT_W-1:0];

  // Bit order id, session_ended, sess ok, power, unplug [RL4]
  wire [EVT_W-1:0] rose = src_sync & ~src_prev;
  wire [EVT_W-1:0] fell = ~src_sync & src_prev;
  wire [EVT_W-1:0] hit = (rose & rise_en) | (fell & fall_en); // [RL1] [RL17]

  wire latch_rd = rd && addr_is(reg_addr_i, `ADDR_LATCH);
  // Event in the read cycle survives so it is not lost
  wire [EVT_W-1:0] next_latch = (latch_rd || low_power_enter_i) ? hit : (latch | hit); // [RL8]

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_prev <= '0;
      latch <= `LATCH_RESET;
      event_irq_o <= 1'b0;
      rxcmd_req_o <= 1'b0;
      rxcmd_level_o <= '0;
    end else begin
      src_prev <= src_sync;
      latch <= next_latch; // [RL7]
      event_irq_o <= |hit; // [RL1]
      rxcmd_req_o <= |hit; // [RL1]
      rxcmd_level_o <= src_sync;
    end
  end

  // Read mux; unimplemented and escape addresses read zero [RL12]
  wire in_rise = (reg_addr_i >= `ADDR_RISE_EN_WR) && (reg_addr_i <= `ADDR_RISE_EN_CLR);
  wire in_fall = (reg_addr_i >= `ADDR_FALL_EN_WR) && (reg_addr_i <= `ADDR_FALL_EN_CLR);
  wire in_scr = (reg_addr_i >= `ADDR_SCRATCH_WR) && (reg_addr_i <= `ADDR_SCRATCH_CLR);
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = `BYTE_ZERO;
    if (!reg_rd_i) begin
      next_rdata = reg_rdata_o;
    end else if (!addr_ok) begin
      next_rdata = `BYTE_ZERO; // [RL15]
    end else if (in_rise) begin
      next_rdata = rise_reg;
    end else if (in_fall) begin
      next_rdata = fall_reg; // [RL3]
    end else if (addr_is(reg_addr_i, `ADDR_LEVEL)) begin
      next_rdata = {3'h0, src_sync}; // [RL5] [RL6]
    end else if (addr_is(reg_addr_i, `ADDR_LATCH)) begin
      next_rdata = {3'h0, latch};
    end else if (addr_is(reg_addr_i, `ADDR_DEBUG)) begin
      next_rdata = {6'h00, line_sync}; // [RL10]
    end else if (in_scr) begin
      next_rdata = scratch;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `BYTE_ZERO;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule : ulpi_phy_event_status_regs

/* bench/ulpi_evt_asserts.sv */
`timescale 1ns/1ps
module ulpi_evt_asserts (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic ext_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic ext_escape_o,
  input wire logic low_power_enter_i,
  input wire logic event_irq_o,
  input wire logic rxcmd_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd_imm = reg_rd_i && !ext_i;
  wire rd_lat = rd_imm && reg_addr_i == 8'h14;
  irq_rxcmd_a: assert property (event_irq_o == rxcmd_req_o)
    else $error("irq and rxcmd differ");
  escape_a: assert property (ext_escape_o == (reg_wr_i && !ext_i && reg_addr_i == 8'h2f))
    else $error("escape pulse wrong");
  level_top_a: assert property (rd_imm && reg_addr_i == 8'h13 |=> reg_rdata_o[7:5] == 3'h0)
    else $error("level top bits set");
  debug_top_a: assert property (rd_imm && reg_addr_i == 8'h15 |=> reg_rdata_o[7:2] == 6'h00)
    else $error("debug top bits set");
  unimp_zero_a: assert property (rd_imm && reg_addr_i inside {[8'h19:8'h2f]}
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  ext_high_a: assert property (reg_rd_i && ext_i && reg_addr_i > 8'h3f |=> reg_rdata_o == 8'h00)
    else $error("high extended read not zero");
  read_clear_a: assert property (rd_lat ##1 (rd_lat && !event_irq_o) |=> reg_rdata_o == 8'h00)
    else $error("latch not cleared by read");
  sleep_clear_a: assert property (low_power_enter_i ##1
    (low_power_enter_i && rd_lat && !event_irq_o) |=> reg_rdata_o == 8'h00)
    else $error("latch not cleared by sleep");
  cover property (event_irq_o);
  cover property (rd_lat ##1 reg_rdata_o != 8'h00);
  cover property (ext_escape_o);
endmodule : ulpi_evt_asserts

/* bench/ulpi_link_model.sv */
`timescale 1ns/1ps
module ulpi_link_model (
  // Clock
  input wire logic sys_clk_i,
  // Register access
  output logic reg_wr_i,
  output logic reg_rd_i,
  output logic ext_i,
  output logic [7:0] reg_addr_i,
  output logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o
);
  initial go(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
  // One request, held up to the edge that takes it
  task automatic go(input logic w, input logic r, input logic x, input logic [7:0] a,
    input logic [7:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    ext_i <= x;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
  endtask : go
  // Released lines flip so stale values never look valid; latch reads optional
  task automatic fin(output logic [7:0] q);
    go(1'b0, 1'b0, 1'b0, ~reg_addr_i, ~reg_wdata_i);
    @(negedge sys_clk_i);
    q = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask : fin
endmodule : ulpi_link_model

/* bench/ulpi_phy_event_status_regs_test.sv */
`timescale 1ns/1ps
module ulpi_phy_event_status_regs_test;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic low_power_enter_i = 1'b0;
  logic reg_wr_i, reg_rd_i, ext_i, ext_escape_o, event_irq_o, rxcmd_req_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
  ulpi_evt_pkg::evt_src_t evt_src_i = 5'h00;
  ulpi_evt_pkg::evt_src_t rxcmd_level_o;
  ulpi_evt_pkg::line_cond_t line_cond_i = 2'h0;
  int fails = 0;
  int n_tests = 0;
  int irqs = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) irqs <= irqs + int'(event_irq_o === 1'b1);
  ulpi_phy_event_status_regs ulpi_phy_event_status_regs_inst (.*);
  ulpi_link_model ulpi_link_model_inst (.*);
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic x = 1'b0);
    ulpi_link_model_inst.go(1'b0, 1'b1, x, a, 8'h00);
    ulpi_link_model_inst.fin(q);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic x = 1'b0);
    ulpi_link_model_inst.go(1'b1, 1'b0, x, a, d);
    ulpi_link_model_inst.fin(q);
  endtask : wr
  // Two sync flops plus the event register
  task automatic settle;
    repeat (4) @(posedge sys_clk_i);
  endtask : settle
  // Bit 17 extended, bit 16 read, then address and data or expected byte
  task automatic t_regs;
    logic [23:0] t [24] = '{24'h01101f, 24'h011600, 24'h011400, 24'h00100a, 24'h01110a,
      24'h001115, 24'h01121f, 24'h001203, 24'h01101c, 24'h0016a5, 24'h00175a, 24'h00180f,
      24'h0117f0, 24'h0020ff, 24'h002fff, 24'h012000, 24'h012f00, 24'h0316f0, 24'h02163c,
      24'h01163c, 24'h0245ff, 24'h034500, 24'h01183c, 24'h00101f};
    foreach (t[i]) begin
      if (t[i][16]) rd(t[i][15:8], t[i][17]);
      else wr(t[i][15:8], t[i][7:0], t[i][17]);
      if (t[i][16]) chk("register", q, t[i][7:0]);
    end
  endtask : t_regs
  task automatic t_event;
    evt_src_i <= 5'h1f;
    settle();
    rd(8'h13);
    chk("levels", q, 8'h1f);
    chk("rxcmd level", 8'(rxcmd_level_o), 8'h1f);
    rd(8'h14);
    chk("rise latch", q, 8'h1f);
    ulpi_link_model_inst.go(1'b0, 1'b1, 1'b0, 8'h14, 8'h00);
    rd(8'h14);
    chk("reread latch", q, 8'h00);
    wr(8'h10, 8'h10);
    evt_src_i <= 5'h00;
    settle();
    rd(8'h14);
    chk("fall latch", q, 8'h10);
    wr(8'h10, 8'h00);
    evt_src_i <= 5'h01;
    settle();
    evt_src_i <= 5'h00;
    settle();
    rd(8'h14);
    chk("masked fall", q, 8'h01);
    chk("irq pulses", 8'(irqs), 8'h03);
    evt_src_i <= 5'h02;
    settle();
    low_power_enter_i <= 1'b1;
    ulpi_link_model_inst.go(1'b0, 1'b0, 1'b0, 8'hff, 8'h00);
    ulpi_link_model_inst.go(1'b0, 1'b1, 1'b0, 8'h14, 8'h00);
    low_power_enter_i <= 1'b0;
    ulpi_link_model_inst.fin(q);
    chk("sleep clear", q, 8'h00);
    line_cond_i <= 2'h2;
    settle();
    rd(8'h15);
    chk("line state", q, 8'h02);
  endtask : t_event
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    rst_n_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_event();
    close_out();
  end
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    fails++;
    close_out();
  end
endmodule : ulpi_phy_event_status_regs_test
bind ulpi_phy_event_status_regs ulpi_evt_asserts ulpi_evt_asserts_inst (.*);
